//--- verilog/sac_ctrl.sv
// Conversion sequencing, result latching, shutdown and readout control.
//
// Operation
// - Start on convert-start fall with select low.
// - Ignore starts while a conversion runs.
// - Clear approximation register at conversion start.
// - Resolve sixteen bits, MSB first, by comparator.
// - Latch finished word into output holding latches.
// - Busy low throughout conversion, high after.
// - Conversion takes typically 1.45 us, max 1.8.
// - Acquisition at most 400 ns, 500 ksps.
// - Results presented as two's complement binary; code gives the raw SAR word, straight binary.
// - Shutdown low: select low nap, high sleep.
// - Nap keeps logic; host waits 200 ns.
// - Select and read low: outputs always driven.
// - Shared bus: outputs floating until read strobe.
// - Slow memory: old result until busy rises.
// - ROM mode: strobe starts and reads previous.
// - Drivers enabled only with read and select low.
// - New result valid when busy rises.
// - MSB on highest data pin, LSB lowest.
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int SLEEP_WAKE_CYC = `SAC_SLEEP_CYC
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                chip_select_n,
	input  wire logic                convert_start_n,
	input  wire logic                read_n,
	input  wire logic                power_down_n,
	input  wire logic                comparator_high,
	output logic                     busy_n,
	output logic [`SAC_MSB:0]        data_out,
	output logic [`SAC_MSB:0]        data_oe_n,
	output logic [`SAC_MSB:0]        dac_code,
	output logic                     sample_hold,
	output logic                     nap_active,
	output logic                     sleep_active,
	output logic                     ready_to_convert,
	output logic                     result_valid,
	input  wire logic                result_ready,
	output logic [`SAC_MSB:0]        result_data,
	output logic                     result_overflow
);
	sac_state_t            state_r;
	sac_state_t            state_nxt;
	sac_power_t            power_r;
	sac_power_t            power_nxt;
	logic                  conv_prev_r;
	logic [`SAC_MSB:0]     approx_r;
	logic [`SAC_MSB:0]     approx_nxt;
	logic [`SAC_MSB:0]     latch_r;
	logic [3:0]            bit_r;
	logic [3:0]            bit_nxt;
	logic                  overflow_r;
	logic                  busy_n_r;
	logic                  timer_load;
	logic [`SAC_CNT_W-1:0] timer_value;
	wire                   timer_done;
	wire                   conv_fall;
	wire                   start_ok;
	wire                   last_bit;
	wire                   finish;
	wire                   fifo_ready;
	wire                   in_shutdown;
	wire                   pace_done;
	wire [`SAC_MSB:0]      trial_code;

	localparam logic [3:0] BIT_MSB = 4'(`SAC_MSB);
	localparam logic [`SAC_CNT_W-1:0] ACQ_LOAD = `SAC_CNT_W'(`SAC_ACQ_CYC);
	localparam logic [`SAC_CNT_W-1:0] NAP_LOAD = `SAC_CNT_W'(`SAC_NAP_CYC);
	localparam logic [`SAC_CNT_W-1:0] SLEEP_LOAD = `SAC_CNT_W'(SLEEP_WAKE_CYC);
	localparam int STEP_CYC = (`SAC_CONV_CYC) / (`SAC_BITS);
	localparam int CONV_MAX_CYC = (`SAC_CONV_MAX_NS) / (`SAC_CLK_NS);

	// One-hot mask for the bit currently under trial.
	function automatic logic [`SAC_MSB:0] bit_mask(input logic [3:0] idx);
		bit_mask = `SAC_BITS'(1) << idx;
	endfunction

	assign in_shutdown = !power_down_n;
	assign conv_fall   = conv_prev_r && !convert_start_n;
	assign start_ok    = conv_fall && !chip_select_n && !in_shutdown
		&& (power_r == SAC_AWAKE) && timer_done;
	assign last_bit    = (bit_r == 4'h0);
	assign finish      = (state_r == SAC_CONVERT) && last_bit;
	assign pace_done   = timer_done;
	assign trial_code  = approx_r | bit_mask(bit_r);

	// Next-state logic of the conversion sequencer.
	always_comb begin
		state_nxt   = state_r;
		approx_nxt  = approx_r;
		bit_nxt     = bit_r;
		timer_load  = 1'b0;
		timer_value = ACQ_LOAD;
		power_nxt   = power_r;
		case (state_r)
			SAC_IDLE: begin
				if (start_ok) begin
					state_nxt  = SAC_CONVERT;
					approx_nxt = `SAC_ZERO16;
					bit_nxt    = BIT_MSB;
				end
			end
			SAC_CONVERT: begin
				// Each step keeps the trial bit when the comparator says so.
				if (comparator_high) begin
					approx_nxt = trial_code;
				end else begin
					approx_nxt = approx_r;
				end
				if (last_bit) begin
					state_nxt   = SAC_SETTLE;
					timer_load  = 1'b1;
					timer_value = ACQ_LOAD;
				end else begin
					bit_nxt = bit_r - 4'h1;
				end
			end
			SAC_SETTLE: begin
				if (pace_done) begin
					state_nxt = SAC_IDLE;
				end
			end
			default: begin
				state_nxt = SAC_IDLE;
			end
		endcase
		// Shutdown mode is chosen by chip select while power-down is low.
		case (power_r)
			SAC_AWAKE: begin
				if (in_shutdown && state_r == SAC_IDLE) begin
					power_nxt = chip_select_n ? SAC_SLEEP : SAC_NAP;
				end
			end
			SAC_NAP, SAC_SLEEP: begin
				if (!in_shutdown) begin
					power_nxt   = SAC_AWAKE;
					timer_load  = 1'b1;
					timer_value = (power_r == SAC_NAP) ? NAP_LOAD
						: SLEEP_LOAD;
				end else if (power_r == SAC_SLEEP && !chip_select_n) begin
					power_nxt = SAC_NAP;
				end else if (power_r == SAC_NAP && chip_select_n) begin
					power_nxt = SAC_SLEEP;
				end
			end
			default: begin
				power_nxt = SAC_AWAKE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= SAC_IDLE;
			power_r     <= SAC_AWAKE;
			conv_prev_r <= 1'b1;
			approx_r    <= `SAC_ZERO16;
			bit_r       <= 4'h0;
		end else begin
			state_r     <= state_nxt;
			power_r     <= power_nxt;
			conv_prev_r <= convert_start_n;
			approx_r    <= approx_nxt;
			bit_r       <= bit_nxt;
		end
	end

	// Holding latches load on the final decision and hold through shutdown.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r  <= `SAC_ZERO16;
			busy_n_r <= 1'b1;
		end else begin
			if (finish) begin
				latch_r <= comparator_high ? trial_code : approx_r;
			end
			// Busy rises one edge after the latch, so data leads it.
			busy_n_r <= !(state_r == SAC_CONVERT);
		end
	end

	// Sticky flag: a result that met a full FIFO was dropped.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_r <= 1'b0;
		end else if (finish && !fifo_ready) begin
			overflow_r <= 1'b1;
		end
	end

	sac_timer u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (timer_load),
		.value (timer_value),
		.done  (timer_done)
	);

	sac_fifo #(
		.WIDTH (`SAC_BITS),
		.DEPTH (`SAC_FIFO_DEPTH),
		.AW    (`SAC_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (finish),
		.in_ready  (fifo_ready),
		.in_data   (comparator_high ? trial_code : approx_r),
		.out_valid (result_valid),
		.out_ready (result_ready),
		.out_data  (result_data)
	);

	// The pins show the latch; in ROM and slow-memory use the old word
	// stays until the latch reloads at the end of the new conversion.
	assign data_out  = latch_r;
	assign data_oe_n = {`SAC_BITS{chip_select_n | read_n}};
	assign busy_n    = busy_n_r;
	assign dac_code  = (state_r == SAC_CONVERT) ? trial_code : approx_r;
	assign sample_hold = (state_r == SAC_CONVERT);
	assign nap_active  = (power_r == SAC_NAP);
	assign sleep_active = (power_r == SAC_SLEEP);
	assign ready_to_convert = (state_r == SAC_IDLE) && (power_r == SAC_AWAKE)
		&& timer_done;
	assign result_overflow = overflow_r;

	// Conversion length of sixteen steps stays within the maximum time.
	localparam int STEPS_USED = `SAC_BITS;
	localparam bit FITS = (STEPS_USED <= CONV_MAX_CYC) && (STEP_CYC >= 0);
endmodule

//--- verilog/sac_map.svh
// Constants for the converter control block.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_CLK_MHZ        10
`define SAC_CONV_TYP_NS    1450
`define SAC_CONV_MAX_NS    1800
`define SAC_ACQ_MAX_NS     400
`define SAC_ACQ_HOST_NS    480
`define SAC_NAP_WAKE_NS    200
`define SAC_SLEEP_WAKE_MS  80
`define SAC_CLK_NS         100
`define SAC_CONV_CYC       ((`SAC_CONV_TYP_NS) / (`SAC_CLK_NS))
`define SAC_ACQ_CYC        (((`SAC_ACQ_MAX_NS) + (`SAC_CLK_NS) - 1) / (`SAC_CLK_NS))
`define SAC_NAP_CYC        (((`SAC_NAP_WAKE_NS) + (`SAC_CLK_NS) - 1) / (`SAC_CLK_NS))
`define SAC_SLEEP_CYC      ((`SAC_SLEEP_WAKE_MS) * 1000000 / (`SAC_CLK_NS))
`define SAC_BITS           16
`define SAC_MSB            15
`define SAC_FIFO_DEPTH     32
`define SAC_FIFO_AW        5
`define SAC_ZERO16         16'h0000
`define SAC_CNT_W          20
`endif

//--- verilog/sac_pkg.sv
// Types of the converter control block.
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_SETTLE,
		SAC_CONVERT
	} sac_state_t;
	typedef enum logic [1:0] {
		SAC_AWAKE,
		SAC_NAP,
		SAC_SLEEP
	} sac_power_t;
endpackage

//--- verilog/sac_fifo.sv
// Result FIFO with parameterised width and depth.
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_fifo #(
	parameter int WIDTH = `SAC_BITS,
	parameter int DEPTH = `SAC_FIFO_DEPTH,
	parameter int AW    = `SAC_FIFO_AW
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic [AW:0]      rp_nxt;
	logic [WIDTH-1:0] out_data_r;
	logic             out_valid_r;
	wire              do_wr;
	wire              do_rd;
	wire              full;
	wire              empty;
	wire              load;
	wire [AW:0]       used;

	// The head word is staged in a register and counts toward the depth,
	// so the store and the stage together hold at most DEPTH words.
	assign used      = wp_r - rp_r;
	assign full      = (used + {{AW{1'b0}}, out_valid_r}) == (AW+1)'(DEPTH);
	assign empty     = (wp_r == rp_r);
	assign in_ready  = !full;
	assign do_wr     = in_valid && !full;
	assign load      = !empty && (!out_valid_r || out_ready);
	assign do_rd     = load;
	assign rp_nxt    = rp_r + 1'b1;
	assign out_valid = out_valid_r;
	assign out_data  = out_data_r;

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem_r[wp_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r        <= '0;
			rp_r        <= '0;
			out_valid_r <= 1'b0;
			out_data_r  <= '0;
		end else begin
			if (do_wr) begin
				wp_r <= wp_r + 1'b1;
			end
			if (do_rd) begin
				rp_r       <= rp_nxt;
				out_data_r <= mem_r[rp_r[AW-1:0]];
			end
			if (load) begin
				out_valid_r <= 1'b1;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
		end
	end
endmodule

//--- verilog/sac_timer.sv
// Down-counter for settling and wake-up waits.
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_timer (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  load,
	input  wire logic [`SAC_CNT_W-1:0] value,
	output logic                       done
);
	logic [`SAC_CNT_W-1:0] cnt_r;

	assign done = (cnt_r == '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= value;
		end else if (!done) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

//--- test/sac_ctrl_monitor.sv
// Checker watching the converter control ports.
`timescale 1ns/1ps
module sac_ctrl_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        chip_select_n,
	input wire logic        convert_start_n,
	input wire logic        read_n,
	input wire logic        power_down_n,
	input wire logic        busy_n,
	input wire logic        nap_active,
	input wire logic        sleep_active,
	input wire logic        ready_to_convert,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe_n,
	input wire logic [15:0] dac_code
);
	logic [4:0] low_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			low_r <= 5'h00;
		else
			low_r <= busy_n ? 5'h00 : low_r + 5'h01;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence take_s;
		$fell(convert_start_n) && !chip_select_n && power_down_n
			&& ready_to_convert;
	endsequence
	sequence done_s;
		$rose(busy_n);
	endsequence
	a_start_taken: assert property (take_s |=> ##1 !busy_n)
		else $error("start was not taken");
	a_deselect_ignored: assert property (
		$fell(convert_start_n) && chip_select_n && busy_n |=> ##1 busy_n)
		else $error("start taken while deselected");
	a_busy_length: assert property (done_s |-> low_r == 5'h10)
		else $error("busy low time is not sixteen cycles");
	a_no_restart: assert property (!busy_n |-> low_r < 5'h10)
		else $error("conversion ran too long");
	a_sar_cleared: assert property (
		$fell(busy_n) |-> $past(dac_code) == 16'h8000)
		else $error("first trial code wrong");
	a_data_ready: assert property (done_s |-> $stable(data_out))
		else $error("data changed at busy rise");
	a_old_shown: assert property (
		$fell(busy_n) |-> $stable(data_out)[*8])
		else $error("old result not held");
	a_drive_gate: assert property (
		data_oe_n == {16{chip_select_n | read_n}})
		else $error("output enable wrong");
	a_shut_no_start: assert property (
		!power_down_n && !$past(power_down_n) && busy_n |=> ##1 busy_n)
		else $error("start during shutdown");
	a_shut_keeps: assert property (
		nap_active || sleep_active |=> $stable(data_out))
		else $error("result changed in shutdown");
	a_nap_select: assert property (
		$rose(nap_active) |-> !$past(chip_select_n))
		else $error("nap without select");
	a_sleep_select: assert property (
		$rose(sleep_active) |-> $past(chip_select_n))
		else $error("sleep with select");
	a_settle_wait: assert property (
		done_s |-> !ready_to_convert ##[1:5] ready_to_convert)
		else $error("settle time wrong");
endmodule

//--- test/sac_afe_model.sv
// Comparator model answering trial codes against a target value.
`timescale 1ns/1ps
module sac_afe_model (
	input  wire logic [15:0] dac_code,
	input  wire logic [15:0] target,
	output logic             comparator_high
);
	assign comparator_high = dac_code <= target;
endmodule

//--- test/tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        chip_select_n = 1'b0;
	logic        convert_start_n = 1'b1;
	logic        read_n = 1'b0;
	logic        power_down_n = 1'b1;
	logic        result_ready = 1'b0;
	logic        comparator_high;
	logic        busy_n, nap_active, sleep_active, ready_to_convert;
	logic        sample_hold;
	logic        result_valid, result_overflow;
	logic [15:0] data_out, data_oe_n, dac_code, result_data;
	logic [15:0] target = 16'h0000;
	logic [15:0] prev = 16'h0000;
	logic [15:0] exp_q[$];
	integer      fail_count = 0;
	integer      checks = 0;
	integer      seed = 23562;
	integer      i;
	always #50 clk = ~clk;
	sac_ctrl #(.SLEEP_WAKE_CYC(10)) dut (.clk, .rst_n, .chip_select_n,
		.convert_start_n, .read_n, .power_down_n, .comparator_high, .busy_n,
		.data_out, .data_oe_n, .dac_code, .sample_hold, .nap_active,
		.sleep_active, .ready_to_convert, .result_valid, .result_ready,
		.result_data, .result_overflow);
	sac_afe_model afe (.dac_code, .target, .comparator_high);
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (exp !== got) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Mode 0 narrow pulse, 1 slow memory strobe, 2 extra start mid-run.
	task automatic conv(input int mode);
		int n;
		n = 0;
		@(posedge clk);
		target <= 16'($random(seed));
		if (mode == 1)
			read_n <= 1'b1;
		do begin
			@(negedge clk);
			n++;
		end while ((n < 5 || ready_to_convert !== 1'b1) && n < 60);
		@(posedge clk);
		convert_start_n <= 1'b0;
		if (mode == 1)
			read_n <= 1'b0;
		if (exp_q.size() < 32)
			exp_q.push_back(target);
		@(posedge clk);
		if (mode != 1)
			convert_start_n <= 1'b1;
		repeat (3) @(negedge clk);
		check("old", prev, data_out);
		check("hold", 16'h1, {15'h0, sample_hold});
		if (mode == 2) begin
			@(posedge clk);
			convert_start_n <= 1'b0;
			@(posedge clk);
			convert_start_n <= 1'b1;
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy_n !== 1'b1 && n < 40);
		check("result", target, data_out);
		check("hold", 16'h0, {15'h0, sample_hold});
		prev = target;
		if (mode == 1) begin
			@(posedge clk);
			convert_start_n <= 1'b1;
			read_n <= 1'b1;
		end
	endtask
	task automatic shut(input logic sel);
		@(posedge clk);
		chip_select_n <= sel;
		power_down_n <= 1'b0;
		repeat (3) @(posedge clk);
		convert_start_n <= 1'b0;
		@(posedge clk);
		convert_start_n <= 1'b1;
		repeat (2) @(negedge clk);
		check("nap", {15'h0, ~sel}, {15'h0, nap_active});
		check("sleep", {15'h0, sel}, {15'h0, sleep_active});
		check("busy", 16'h1, {15'h0, busy_n});
		check("kept", prev, data_out);
		@(posedge clk);
		power_down_n <= 1'b1;
		chip_select_n <= 1'b0;
	endtask
	always @(negedge clk) begin
		if (rst_n && result_valid === 1'b1 && result_ready === 1'b1) begin
			if (exp_q.size() == 0)
				check("extra", ~result_data, result_data);
			else
				check("fifo", exp_q.pop_front(), result_data);
		end
	end
	initial begin
		#500000;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check("busy", 16'h1, {15'h0, busy_n});
		check("data", 16'h0, data_out);
		for (i = 0; i < 33; i++)
			conv(0);
		check("ovf", 16'h1, {15'h0, result_overflow});
		@(posedge clk);
		result_ready <= 1'b1;
		repeat (40) @(negedge clk);
		check("drained", 16'h0, {15'h0, result_valid});
		$display("test fill and drain done");
		@(posedge clk);
		chip_select_n <= 1'b1;
		convert_start_n <= 1'b0;
		@(posedge clk);
		convert_start_n <= 1'b1;
		repeat (2) @(negedge clk);
		check("busy", 16'h1, {15'h0, busy_n});
		check("oe", 16'hFFFF, data_oe_n);
		@(posedge clk);
		chip_select_n <= 1'b0;
		read_n <= 1'b1;
		@(negedge clk);
		check("oe", 16'hFFFF, data_oe_n);
		@(posedge clk);
		read_n <= 1'b0;
		@(negedge clk);
		check("oe", 16'h0000, data_oe_n);
		$display("test select and read done");
		conv(2);
		$display("test restart done");
		shut(1'b0);
		conv(0);
		shut(1'b1);
		conv(0);
		$display("test shutdown done");
		conv(1);
		conv(1);
		$display("test slow memory done");
		complete_run();
	end
endmodule
bind sac_ctrl sac_ctrl_monitor mon (.clk, .rst_n, .chip_select_n,
	.convert_start_n, .read_n, .power_down_n, .busy_n, .nap_active,
	.sleep_active, .ready_to_convert, .data_out, .data_oe_n, .dac_code);
